// ---- design/pwmtb_params.svh ----
// Offsets, field positions, reset values and widths for the period and phase block.
// Assumes a 32-bit register port with byte addresses and two 16-bit half-word write enables.
//
// Contract
// - Period fraction lives in bits 15 to 8.
// - Period fraction always reaches its shadow copy.
// - Fraction counts only with high resolution enabled.
// - Legacy and mirror reach the same period.
// - Period and fraction mirrors share one word.
// - Period mirror reads return the active period.
// - Shadow mode loads active period at zero.
// - Immediate mode writes the active period directly.
// - Both fraction locations write the period fraction.
// - Phase loading off leaves sync events ignored.
// - Phase loading on loads phase at sync.
// - Sync comes from pin or software force.
// - Phase value sets offset from upstream base.
// - Phase fraction lives in bits 31 to 24.
`ifndef PWMTB_PARAMS_SVH
`define PWMTB_PARAMS_SVH

`define PWMTB_ADDR_W          8
`define PWMTB_DATA_W          32
`define PWMTB_VAL_W           16
`define PWMTB_FRAC_W          8

`define PWMTB_OFS_PERIOD      8'h00
`define PWMTB_OFS_PRD_FRAC    8'h04
`define PWMTB_OFS_PRD_MIRROR  8'h08
`define PWMTB_OFS_PHASE       8'h0C
`define PWMTB_OFS_CONTROL     8'h10
`define PWMTB_OFS_COUNT       8'h14
`define PWMTB_OFS_HR_CTRL     8'h18

`define PWMTB_FRAC_MSB        15
`define PWMTB_FRAC_LSB        8
`define PWMTB_HI_FRAC_MSB     31
`define PWMTB_HI_FRAC_LSB     24
`define PWMTB_BIT_PHASE_EN    2
`define PWMTB_BIT_LOAD_MODE   3
`define PWMTB_BIT_SW_SYNC     6
`define PWMTB_BIT_HR_EN       0

`define PWMTB_RST_VAL         16'h0000
`define PWMTB_RST_FRAC        8'h00

`endif

// ---- design/pwmtb_pkg.sv ----
// Types shared by the period and phase block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "pwmtb_params.svh"

package pwmtb_pkg;

    typedef struct packed {
        logic [`PWMTB_ADDR_W-1:0] addr;
        logic [`PWMTB_DATA_W-1:0] wdata;
        logic [1:0]               half;
        logic                     wr;
        logic                     rd;
    } pwmtb_bus_req_t;

    typedef struct packed {
        logic [`PWMTB_VAL_W-1:0]  value;
        logic [`PWMTB_FRAC_W-1:0] frac;
    } pwmtb_hr_val_t;

endpackage

`default_nettype wire

// ---- design/pwmtb_sync_in.sv ----
// Synchroniser and rising-edge detector for the sync input pin.
// Assumes the pin is asynchronous to clk_sys_in.
`default_nettype none
`include "pwmtb_params.svh"

module pwmtb_sync_in
    import pwmtb_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic pin_in,
    output logic      rise_out
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // The first stage feeds only the second stage, so no logic sees a metastable level.
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else if (ce_in)
        begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign rise_out = sync_r & ~prev_r;

endmodule

`default_nettype wire

// ---- design/pwmtb_counter.sv ----
// Up-counting time-base counter with phase load and software write.
// Assumes the period input is the active period, stable between its own updates.
`default_nettype none
`include "pwmtb_params.svh"

module pwmtb_counter
    import pwmtb_pkg::*;
#(
    parameter int VAL_W = `PWMTB_VAL_W
)
(
    input  wire logic             clk_sys_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [VAL_W-1:0] period_in,
    input  wire logic             load_in,
    input  wire logic [VAL_W-1:0] load_val_in,
    input  wire logic             wr_in,
    input  wire logic [VAL_W-1:0] wr_val_in,
    output logic      [VAL_W-1:0] count_out,
    output logic                  zero_out
);

    logic [VAL_W-1:0] count_r;
    logic [VAL_W-1:0] count_nxt;
    wire              wrap = (count_r >= period_in);

    // A sync load takes priority over a software write, which beats counting.
    assign count_nxt = load_in ? load_val_in :
                       wr_in   ? wr_val_in   :
                       wrap    ? '0          : count_r + 1'b1;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            count_r <= '0;
        else if (ce_in)
            count_r <= count_nxt;
    end

    assign count_out = count_r;
    assign zero_out  = (count_r == '0);

endmodule

`default_nettype wire

// ---- design/pwmtb_top.sv ----
// Period and phase register set of a PWM time-base, with its counter.
// Assumes a register master on clk_sys_in and an asynchronous sync pin.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`default_nettype none
`include "pwmtb_params.svh"

module pwmtb_top
    import pwmtb_pkg::*;
#(
    parameter int VAL_W  = `PWMTB_VAL_W,
    parameter int FRAC_W = `PWMTB_FRAC_W
)
(
    input  wire logic                      clk_sys_in,
    input  wire logic                      rst_in,
    input  wire logic                      ce_in,
    input  wire pwmtb_bus_req_t            bus_in,
    output logic     [`PWMTB_DATA_W-1:0]   rd_data_out,
    input  wire logic                      sync_pin_in,
    output logic     [VAL_W-1:0]           count_out,
    output logic                           zero_out,
    output pwmtb_hr_val_t                  eff_period_out,
    output pwmtb_hr_val_t                  phase_out
);

    // Register state.
    logic [VAL_W-1:0]         prd_shadow_r;
    logic [VAL_W-1:0]         prd_active_r;
    logic [FRAC_W-1:0]        frac_shadow_r;
    logic [FRAC_W-1:0]        frac_active_r;
    logic [VAL_W-1:0]         phase_r;
    logic [FRAC_W-1:0]        phase_frac_r;
    logic                     phase_en_r;
    logic                     load_mode_r;
    logic                     hr_en_r;
    logic [`PWMTB_DATA_W-1:0] rd_data_r;
    logic [`PWMTB_DATA_W-1:0] rd_data_nxt;
    pwmtb_hr_val_t            eff_period_r;
    pwmtb_hr_val_t            eff_period_nxt;

    logic [VAL_W-1:0] count;
    logic             ctr_zero;
    logic             pin_rise;

    // Address decode.
    wire wr     = bus_in.wr;
    wire lo     = bus_in.half[0];
    wire hi     = bus_in.half[1];
    wire hit_pl = (bus_in.addr == `PWMTB_OFS_PERIOD);
    wire hit_pf = (bus_in.addr == `PWMTB_OFS_PRD_FRAC);
    wire hit_pm = (bus_in.addr == `PWMTB_OFS_PRD_MIRROR);
    wire hit_ph = (bus_in.addr == `PWMTB_OFS_PHASE);
    wire hit_ct = (bus_in.addr == `PWMTB_OFS_CONTROL);
    wire hit_cn = (bus_in.addr == `PWMTB_OFS_COUNT);
    wire hit_hr = (bus_in.addr == `PWMTB_OFS_HR_CTRL);

    wire [VAL_W-1:0]  wr_lo   = bus_in.wdata[VAL_W-1:0];
    wire [FRAC_W-1:0] wr_frac = bus_in.wdata[`PWMTB_FRAC_MSB:`PWMTB_FRAC_LSB];
    wire [FRAC_W-1:0] wr_hfr  = bus_in.wdata[`PWMTB_HI_FRAC_MSB:`PWMTB_HI_FRAC_LSB];

    // Legacy and mirror period locations both reach the one period pair.
    wire wr_period   = wr & lo & (hit_pl | hit_pm);
    wire wr_prd_act  = wr_period & load_mode_r;
    wire wr_prd_shd  = wr_period & ~load_mode_r;
    // The fraction mirror is the upper half of the mirror word, so one write sets both.
    wire wr_frac_lo  = wr & lo & hit_pf;
    wire wr_frac_hi  = wr & hi & hit_pm;
    wire wr_ctrl     = wr & lo & hit_ct;
    wire sw_sync     = wr_ctrl & bus_in.wdata[`PWMTB_BIT_SW_SYNC];
    wire sync_evt    = pin_rise | sw_sync;
    wire phase_load  = sync_evt & phase_en_r;
    wire wr_count    = wr & lo & hit_cn;

    // Only the fraction byte of a word is stored, bits 15 to 8 or 31 to 24; the low byte of the fraction word has no flops.
    wire [FRAC_W-1:0] frac_nxt = wr_frac_lo ? wr_frac :
                                 wr_frac_hi ? wr_hfr  : frac_shadow_r;

    // The period value sits in the low half, its fraction in bits 15 to 8 of the fraction word.
    function automatic logic [`PWMTB_DATA_W-1:0] frac_word(input logic [FRAC_W-1:0] f);
        frac_word = {16'h0000, f, 8'h00};
    endfunction

    function automatic logic [`PWMTB_DATA_W-1:0] val_word(input logic [VAL_W-1:0] v);
        val_word = {16'h0000, v};
    endfunction

    // The legacy location shows the shadow in shadow mode; the mirror always shows the active
    // value. The upper half of the mirror word reads zero because its contents are undefined.
    wire [VAL_W-1:0] legacy_view = load_mode_r ? prd_active_r : prd_shadow_r;

    always_comb
    begin
        rd_data_nxt = '0;
        if (bus_in.rd)
        begin
            if (hit_pl)
                rd_data_nxt = val_word(legacy_view);
            else if (hit_pf)
                rd_data_nxt = frac_word(frac_shadow_r);
            else if (hit_pm)
                rd_data_nxt = val_word(prd_active_r);
            else if (hit_ph)
                rd_data_nxt = {phase_frac_r, 8'h00, phase_r};
            else if (hit_ct)
                rd_data_nxt = {28'h0000000, load_mode_r, phase_en_r, 2'h0};
            else if (hit_cn)
                rd_data_nxt = val_word(count);
            else if (hit_hr)
                rd_data_nxt = {31'h00000000, hr_en_r};
        end
    end

    // The fraction only shapes the period when high resolution is on.
    assign eff_period_nxt.value = prd_active_r;
    assign eff_period_nxt.frac  = hr_en_r ? frac_active_r : '0;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prd_shadow_r  <= `PWMTB_RST_VAL;
            prd_active_r  <= `PWMTB_RST_VAL;
            frac_shadow_r <= `PWMTB_RST_FRAC;
            frac_active_r <= `PWMTB_RST_FRAC;
            phase_r       <= `PWMTB_RST_VAL;
            phase_frac_r  <= `PWMTB_RST_FRAC;
        end
        else if (ce_in)
        begin
            if (wr_prd_shd)
                prd_shadow_r <= wr_lo;
            if (wr_prd_act)
                prd_active_r <= wr_lo;
            else if (ctr_zero && !load_mode_r)
                prd_active_r <= prd_shadow_r;
            frac_shadow_r <= frac_nxt;
            // The fraction has no immediate mode, so it always moves across at zero.
            if (ctr_zero)
                frac_active_r <= frac_shadow_r;
            if (wr && lo && hit_ph)
                phase_r <= wr_lo;
            if (wr && hi && hit_ph)
                phase_frac_r <= wr_hfr;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            phase_en_r   <= 1'b0;
            load_mode_r  <= 1'b0;
            hr_en_r      <= 1'b0;
            rd_data_r    <= '0;
            eff_period_r <= '0;
        end
        else if (ce_in)
        begin
            if (wr_ctrl)
            begin
                phase_en_r  <= bus_in.wdata[`PWMTB_BIT_PHASE_EN];
                load_mode_r <= bus_in.wdata[`PWMTB_BIT_LOAD_MODE];
            end
            if (wr && lo && hit_hr)
                hr_en_r <= bus_in.wdata[`PWMTB_BIT_HR_EN];
            rd_data_r    <= rd_data_nxt;
            eff_period_r <= eff_period_nxt;
        end
    end

    pwmtb_sync_in i_pwmtb_sync_in
    (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .pin_in     (sync_pin_in),
        .rise_out   (pin_rise)
    );

    pwmtb_counter #(.VAL_W(VAL_W)) i_pwmtb_counter
    (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .period_in   (prd_active_r),
        .load_in     (phase_load),
        .load_val_in (phase_r),
        .wr_in       (wr_count),
        .wr_val_in   (wr_lo),
        .count_out   (count),
        .zero_out    (ctr_zero)
    );

    assign rd_data_out      = rd_data_r;
    assign count_out        = count;
    assign zero_out         = ctr_zero;
    assign eff_period_out   = eff_period_r;
    assign phase_out.value  = phase_r;
    assign phase_out.frac   = phase_frac_r;

    // Checks on the behaviour above.

    a_shadow_zero_load: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !load_mode_r && ctr_zero && !wr_ctrl)
            |=> (prd_active_r == $past(prd_shadow_r)))
        else $error("active period not loaded from shadow at zero");

    a_immediate_period: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && load_mode_r && wr && lo && hit_pm)
            |=> (prd_active_r == $past(bus_in.wdata[15:0])) && ($stable(prd_shadow_r)))
        else $error("immediate period write did not reach active period");

    a_mirror_reads_active: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && bus_in.rd && hit_pm)
            |=> (rd_data_out == {16'h0000, $past(prd_active_r)}))
        else $error("period mirror read did not return active value");

    a_legacy_shadow_read: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && bus_in.rd && hit_pl && !load_mode_r)
            |=> (rd_data_out[15:0] == $past(prd_shadow_r)))
        else $error("legacy period read did not return shadow in shadow mode");

    a_frac_mirror_write: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && wr && hit_pm && bus_in.half == 2'b11 && !load_mode_r)
            |=> (frac_shadow_r == $past(bus_in.wdata[31:24]))
                && (prd_shadow_r == $past(bus_in.wdata[15:0])))
        else $error("one mirror word write did not set period and fraction");

    a_frac_read_layout: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && bus_in.rd && hit_pf)
            |=> (rd_data_out[7:0] == 8'h00) && (rd_data_out[15:8] == $past(frac_shadow_r)))
        else $error("period fraction read layout wrong");

    a_hr_gates_frac: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !hr_en_r) |=> (eff_period_out.frac == 8'h00))
        else $error("fraction used while high resolution is off");

    a_phase_on_sync: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && phase_en_r && sync_evt) |=> (count_out == $past(phase_r)))
        else $error("counter not loaded with phase on sync");

    a_sync_ignored: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !phase_en_r && sync_evt && !wr_count)
            |=> (count_out == (($past(count) >= $past(prd_active_r)) ? 16'h0000
                                : 16'($past(count) + 16'h0001))))
        else $error("counter disturbed by sync while phase loading is off");

    a_sw_sync_source: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && phase_en_r && wr_ctrl && bus_in.wdata[6]) |-> phase_load)
        else $error("software sync did not raise a sync event");

    a_frac_shadow_only: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && wr_frac_lo) |=> (frac_shadow_r == $past(bus_in.wdata[15:8])))
        else $error("fraction write did not reach its shadow");

    a_legacy_active_read: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && bus_in.rd && hit_pl && load_mode_r)
            |=> (rd_data_out == {16'h0000, $past(prd_active_r)}))
        else $error("legacy period read did not return active in immediate mode");

    a_frac_mirror_half: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && wr && hi && hit_pm)
            |=> (frac_shadow_r == $past(bus_in.wdata[31:24])))
        else $error("fraction mirror write did not reach the fraction shadow");

    // The fraction has no immediate path, so the zero crossing is its only way to the active copy.
    a_frac_zero_load: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && ctr_zero) |=> (frac_active_r == $past(frac_shadow_r)))
        else $error("active fraction not loaded from shadow at zero");

    a_hr_passes_frac: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && hr_en_r) |=> (eff_period_out.frac == $past(frac_active_r)))
        else $error("fraction not used while high resolution is on");

    a_phase_frac_write: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && wr && hi && hit_ph)
            |=> (phase_frac_r == $past(bus_in.wdata[31:24])))
        else $error("phase fraction write did not land");

    a_phase_read_layout: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && bus_in.rd && hit_ph)
            |=> (rd_data_out == {$past(phase_frac_r), 8'h00, $past(phase_r)}))
        else $error("phase read layout wrong");

endmodule

`default_nettype wire

// ---- tb/pwmtb_sync_src.sv ----
// Upstream time-base model that drives the sync pin of the period and phase block.
// Assumes fire_in is a one-cycle request from the bench, spaced well apart.
`default_nettype none

module pwmtb_sync_src
(
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic fire_in,
    output logic      pin_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] hold_r;

    // The pulse is held three cycles so that the two-stage synchroniser cannot miss it.
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            hold_r <= 2'h0;
        else if (fire_in)
            hold_r <= 2'h3;
        else if (hold_r != 2'h0)
            hold_r <= hold_r - 2'h1;
    end

    // Idle level between events is low, so each request gives one clean rising edge.
    assign pin_out = (hold_r != 2'h0);
endmodule

`default_nettype wire

// ---- tb/tb_pwm_timebase_period_phase_regs.sv ----
// Self-checking bench for the period and phase register set.
// Assumes the design files and the sync source model are compiled before it.
`default_nettype none
`include "pwmtb_params.svh"

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module tb_pwm_timebase_period_phase_regs
    import pwmtb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clk_sys_in;
    logic           rst_in;
    logic           ce_in;
    logic           sync_fire;
    pwmtb_bus_req_t bus;
    logic [31:0]    rd_data;
    wire logic      sync_pin;
    logic [15:0]    count;
    logic           zero;
    pwmtb_hr_val_t  eff_period;
    pwmtb_hr_val_t  phase;
    int             fails;
    int             n_tests;
    int             k;
    logic [31:0]    d;
    logic [31:0]    w;
    logic [15:0]    p;
    logic [15:0]    q;
    logic [15:0]    ph;
    logic [7:0]     f;

    pwmtb_top i_pwmtb_top (
        .clk_sys_in     (clk_sys_in),
        .rst_in         (rst_in),
        .ce_in          (ce_in),
        .bus_in         (bus),
        .rd_data_out    (rd_data),
        .sync_pin_in    (sync_pin),
        .count_out      (count),
        .zero_out       (zero),
        .eff_period_out (eff_period),
        .phase_out      (phase)
    );

    pwmtb_sync_src i_pwmtb_sync_src (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .fire_in    (sync_fire),
        .pin_out    (sync_pin)
    );

    initial
    begin
        clk_sys_in = 1'h0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [31:0] exp_frac(input logic [7:0] fr);
        return {16'h0000, fr, 8'h00};
    endfunction

    function automatic logic [31:0] exp_phase(input logic [31:0] wv);
        return {wv[31:24], 8'h00, wv[15:0]};
    endfunction

    task automatic end_sim();
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wv, input logic [1:0] h);
        @(posedge clk_sys_in);
        bus.addr  <= a;
        bus.wdata <= wv;
        bus.half  <= h;
        bus.wr    <= 1'h1;
        @(posedge clk_sys_in);
        bus.wr    <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge clk_sys_in);
        bus.addr <= a;
        bus.rd   <= 1'h1;
        @(posedge clk_sys_in);
        bus.rd   <= 1'h0;
        #1;
        r = rd_data;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        rd(a, r);
        `CHK(r, e)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic wait_zero();
        bit hit;
        hit = 1'b0;
        for (int i = 0; i < 1000 && !hit; i++)
        begin
            @(posedge clk_sys_in);
            #1;
            hit = (zero === 1'h1);
        end
        if (!hit)
        begin
            fails++;
            end_sim();
        end
    endtask

    task automatic sync_check(input logic en, input logic sw);
        logic [31:0] c;
        c = en ? 32'h0000000C : 32'h00000008;
        wr(`PWMTB_OFS_CONTROL, c, 2'h1);
        wr(`PWMTB_OFS_COUNT, 32'h00000100, 2'h1);
        if (sw)
            wr(`PWMTB_OFS_CONTROL, c | 32'h00000040, 2'h1);
        else
        begin
            @(posedge clk_sys_in);
            sync_fire <= 1'h1;
            @(posedge clk_sys_in);
            sync_fire <= 1'h0;
        end
        settle(8);
        `CHK(en ? (count >= ph && count < ph + 16'h0010) : (count < 16'h0200), 1'h1)
    endtask

    initial
    begin
        fails     = 0;
        n_tests   = 0;
        ce_in     = 1'h1;
        rst_in    = 1'h1;
        bus       = '0;
        sync_fire = 1'h0;
        void'($urandom(32'h372EB780));
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'h0;

        // Every location, plus one unmapped word, reads zero out of reset.
        for (k = 0; k < 8; k++)
            chk_rd(8'(k * 4), 32'h00000000);
        `CHK({eff_period, phase}, 48'h000000000000)
        wr(8'h1C, $urandom, 2'h3);
        chk_rd(8'h1C, 32'h00000000);

        for (k = 0; k < 2; k++)
        begin
            wr(`PWMTB_OFS_CONTROL, 32'(k * 8), 2'h1);
            w = $urandom;
            wr(`PWMTB_OFS_PRD_FRAC, w, 2'h3);
            chk_rd(`PWMTB_OFS_PRD_FRAC, exp_frac(w[15:8]));
        end

        wr(`PWMTB_OFS_CONTROL, 32'h00000008, 2'h1);
        p = 16'h0100 | 16'($urandom & 32'h000000FF);
        wr(`PWMTB_OFS_PRD_MIRROR, {16'hFFFF, p}, 2'h1);
        rd(`PWMTB_OFS_PRD_MIRROR, d); // Upper half holds no dependable data.
        `CHK(d[15:0], p)
        chk_rd(`PWMTB_OFS_PERIOD, {16'h0000, p});
        settle(2);
        `CHK(eff_period.value, p)
        // The legacy location must reach the same period that the mirror shows.
        p = p ^ 16'h0001;
        wr(`PWMTB_OFS_PERIOD, {16'hFFFF, p}, 2'h1);
        rd(`PWMTB_OFS_PRD_MIRROR, d);
        `CHK(d[15:0], p)

        // Counter is parked far from its wrap so the shadow cannot load too early.
        wr(`PWMTB_OFS_COUNT, 32'h00000001, 2'h1);
        wr(`PWMTB_OFS_HR_CTRL, 32'h00000001, 2'h1);
        wr(`PWMTB_OFS_CONTROL, 32'h00000000, 2'h1);
        q = 16'h0100 | 16'($urandom & 32'h000000FF);
        f = 8'($urandom);
        w = {f, 8'($urandom), q};
        wr(`PWMTB_OFS_PRD_MIRROR, w, 2'h3);
        rd(`PWMTB_OFS_PRD_MIRROR, d);
        `CHK(d[15:0], p)
        chk_rd(`PWMTB_OFS_PERIOD, {16'h0000, q});
        chk_rd(`PWMTB_OFS_PRD_FRAC, exp_frac(f));
        wait_zero();
        settle(2);
        rd(`PWMTB_OFS_PRD_MIRROR, d);
        `CHK(d[15:0], q)
        `CHK(eff_period, {q, f})
        wr(`PWMTB_OFS_HR_CTRL, 32'h00000000, 2'h1);
        settle(2);
        `CHK(eff_period, {q, 8'h00})

        ph = 16'h8000 | 16'($urandom & 32'h00006FFF);
        w = $urandom;
        w[15:0] = ph;
        wr(`PWMTB_OFS_PHASE, w, 2'h3);
        chk_rd(`PWMTB_OFS_PHASE, exp_phase(w));
        `CHK(phase, {ph, w[31:24]})

        wr(`PWMTB_OFS_CONTROL, 32'h00000008, 2'h1);
        wr(`PWMTB_OFS_PRD_MIRROR, 32'h0000FFFF, 2'h1);
        for (k = 0; k < 4; k++)
            sync_check(k[0], k[1]);
        end_sim();
    end
endmodule

`default_nettype wire
